// file: common/gtm_map.svh
// Purpose: register offsets, field positions, reset values and timing counts of the timer
// Assumes: Avalon-MM byte addressing, avs_address_i compared with the byte addresses given here
// Notes: definitions only
`ifndef GTM_MAP_SVH
`define GTM_MAP_SVH

// ****************************************
// register byte offsets
// ****************************************
`define GTM_OFS_CFG 8'h00
`define GTM_OFS_AMODE 8'h04
`define GTM_OFS_BMODE 8'h08
`define GTM_OFS_CTL 8'h0c
`define GTM_OFS_IMR 8'h18
`define GTM_OFS_RIS 8'h1c
`define GTM_OFS_MIS 8'h20
`define GTM_OFS_ICR 8'h24
`define GTM_OFS_AILR 8'h28
`define GTM_OFS_BILR 8'h2c
`define GTM_OFS_AMATCH 8'h30
`define GTM_OFS_BMATCH 8'h34
`define GTM_OFS_APR 8'h38
`define GTM_OFS_BPR 8'h3c
`define GTM_OFS_ACNT 8'h48
`define GTM_OFS_BCNT 8'h4c

// ****************************************
// configuration values
// ****************************************
`define GTM_CFG_32 3'h0
`define GTM_CFG_CLOCK 3'h1
`define GTM_CFG_16 3'h4

// ****************************************
// mode register fields
// ****************************************
`define GTM_MODE_ONESHOT 2'h1
`define GTM_MODE_PERIODIC 2'h2
`define GTM_MODE_CAPTURE 2'h3
`define GTM_MODE_PWM 2'h2
`define GTM_MR_CMR 2
`define GTM_MR_AMS 3

// ****************************************
// control register fields (timer b at +8)
// ****************************************
`define GTM_CTL_EN 0
`define GTM_CTL_STALL 1
`define GTM_CTL_EVT 2
`define GTM_CTL_STALL_OVR 4
`define GTM_CTL_OTE 5
`define GTM_CTL_INV 6
`define GTM_CTL_B 8

// ****************************************
// status bits: timeout, match, event per timer, b at +8
// ****************************************
`define GTM_ST_TO 0
`define GTM_ST_CM 1
`define GTM_ST_CE 2
`define GTM_ST_RTC 3
`define GTM_ST_B 8

// ****************************************
// reset values and timing
// ****************************************
`define GTM_RST_LOAD 16'hffff
`define GTM_RST_PRE 8'h00
`define GTM_CLOCK_FIRST 32'h00000001
`define GTM_RTC_IN_HZ 32768
`define GTM_RTC_OUT_HZ 1
`define GTM_RTC_DIV (`GTM_RTC_IN_HZ / `GTM_RTC_OUT_HZ)

`endif

// file: common/gtm_pkg.sv
// Purpose: types shared by the timer files
// Assumes: constants live in gtm_map.svh
// Notes: none
package gtm_pkg;

	// ****************************************
	// per-half settings
	// ****************************************
	typedef struct packed {
		logic [1:0] mode;
		logic cmr;
		logic ams;
		logic [1:0] evt;
		logic stall;
		logic inv;
		logic ote;
		logic [15:0] load;
		logic [15:0] match;
		logic [7:0] pre;
	} gtm_half_cfg_t;

	typedef struct packed {
		logic timeout;
		logic count_match;
		logic edge_event;
		logic done;
		logic trigger;
		logic pwm;
		logic [15:0] count;
		logic [15:0] capture;
	} gtm_half_stat_t;

	typedef enum logic [1:0] {
		GTM_IDLE,
		GTM_ONE_SHOT,
		GTM_EDGE_COUNT,
		GTM_FREE
	} gtm_kind_t;

endpackage : gtm_pkg

// file: hdl/gtm_half.sv
// Purpose: one 16-bit timer half in split mode
// Assumes: rise_i and fall_i are synchronised one-cycle pulses per input edge
// Notes: load_wr_i reloads on the next cycle while running
`timescale 1ns/10ps
`include "gtm_map.svh"

module gtm_half (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic run_i,
	input wire logic hold_i,
	input wire logic start_i,
	input wire logic load_wr_i,
	input wire logic rise_i,
	input wire logic fall_i,
	input wire gtm_pkg::gtm_half_cfg_t cfg_i,
	output gtm_pkg::gtm_half_stat_t stat_o
);

	logic [15:0] count;
	logic [7:0] pre_cnt;
	logic [15:0] capture;
	logic pwm;
	logic edge_hit;
	logic is_pwm;
	logic is_cap;
	logic use_pre;
	logic at_zero;
	logic timeout;
	logic count_match;
	logic edge_event;
	logic done;
	logic trigger;

	assign is_pwm = cfg_i.ams && !cfg_i.cmr && cfg_i.mode == `GTM_MODE_PWM;
	assign is_cap = !is_pwm && cfg_i.mode == `GTM_MODE_CAPTURE;
	assign use_pre = !is_pwm && !is_cap;
	assign at_zero = count == 16'h0000;
	assign edge_hit = (cfg_i.evt == 2'h0 && rise_i) || (cfg_i.evt == 2'h1 && fall_i)
		|| (cfg_i.evt == 2'h3 && (rise_i || fall_i));

	// ****************************************
	// counter and prescaler
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		timeout <= 1'b0;
		count_match <= 1'b0;
		edge_event <= 1'b0;
		done <= 1'b0;
		trigger <= 1'b0;
		if (!reset_n_i) begin
			count <= `GTM_RST_LOAD;
			pre_cnt <= `GTM_RST_PRE;
			capture <= `GTM_RST_LOAD;
		end else if (start_i || load_wr_i) begin
			count <= cfg_i.load;
			pre_cnt <= cfg_i.pre;
		end else if (run_i && !hold_i) begin
			if (is_cap && !cfg_i.cmr) begin
				if (edge_hit) begin
					if (count - 16'h0001 == cfg_i.match) begin
						count <= cfg_i.load;
						count_match <= 1'b1;
						done <= 1'b1;
					end else begin
						count <= count - 16'h0001;
					end
				end
			end else begin
				if (is_cap && edge_hit) begin
					capture <= count;
					edge_event <= 1'b1;
				end
				if (use_pre && pre_cnt != 8'h00) begin
					pre_cnt <= pre_cnt - 8'h01;
				end else if (at_zero) begin
					count <= cfg_i.load;
					pre_cnt <= cfg_i.pre;
					if (!is_pwm && !is_cap) begin
						timeout <= 1'b1;
						trigger <= cfg_i.ote;
						done <= cfg_i.mode == `GTM_MODE_ONESHOT;
					end
				end else begin
					count <= count - 16'h0001;
					pre_cnt <= use_pre ? cfg_i.pre : 8'h00;
				end
			end
		end
	end

	// ****************************************
	// pwm level
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			pwm <= 1'b0;
		end else if (!run_i || !is_pwm) begin
			pwm <= 1'b0;
		end else if (count == cfg_i.load) begin
			pwm <= 1'b1;
		end else if (count == cfg_i.match) begin
			pwm <= 1'b0;
		end
	end

	always_comb begin
		stat_o.timeout = timeout;
		stat_o.count_match = count_match;
		stat_o.edge_event = edge_event;
		stat_o.done = done;
		stat_o.trigger = trigger;
		stat_o.count = count;
		stat_o.capture = capture;
		stat_o.pwm = pwm ^ cfg_i.inv;
	end

endmodule : gtm_half

// file: hdl/gtm_top.sv
// Purpose: split 16-bit / 32-bit clock-mode timer with an Avalon-MM register slave
// Assumes: 10 MHz core clock, capture pins asynchronous
// Notes: interrupt output taken from the masked status, no other interrupt logic
// Operation
// - clock mode acts as 32-bit up-counter, first loaded with one.
// - even pin carries 32.768 kHz, divided to a 1 Hz counting tick.
// - clock counter counts up, rolls to zero at match, runs until disabled.
// - clock match sets raw and masked flags; clear bit clears both.
// - clock mode keeps running under debug halt when stall override set; code ignores the override and keeps it running under halt either way.
// - configuration four selects split mode with two independent halves.
// - one-shot and periodic use 16-bit down-counter plus 8-bit prescaler.
// - at zero reload next cycle; one-shot clears enable, periodic continues.
// - zero sets timeout flag held until cleared; trigger when enabled.
// - writing interval load while running reloads the counter next cycle; code reloads it with the previous load value, the written one at the next zero.
// - debug stall enable freezes the half while processor halted.
// - prescaler unused in edge count, edge time and pwm modes.
// - capture select zero gives edge count; event field picks edges.
// - each edge decrements until match, then match flags set.
// - after edge count match reload, clear enable, ignore further edges.
// - edge time mode free-runs down from interval load, reset all ones.
// - selected edge copies count to capture register and sets event flag.
// - edge time keeps running after capture, reloads at zero.
// - pwm when alternate select one, capture select zero, mode two.
// - pwm counts down, reloads, repeats, sets no flags.
// - pwm asserts at load value, deasserts at match; invert bit flips it.
// - mode field one is one-shot, two is periodic.
// - configuration one is clock mode, zero is 32-bit one-shot/periodic; code has no 32-bit timer, zero leaves both halves stopped.
//
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`include "gtm_map.svh"

module gtm_top (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic debug_halt_i,
	input wire logic [1:0] capture_compare_pin_i,
	output logic [1:0] capture_compare_pin_o,
	output logic [1:0] capture_compare_pin_oe_o,
	output logic [1:0] converter_trigger_o,
	output logic irq_o
);

	// ****************************************
	// registers
	// ****************************************
	logic [2:0] timer_configuration;
	logic [3:0] timer_a_mode;
	logic [3:0] timer_b_mode;
	logic [15:0] timer_control;
	logic [15:0] interrupt_mask;
	logic [15:0] raw_interrupt_status;
	logic [15:0] load_a;
	logic [15:0] load_b;
	logic [15:0] match_a;
	logic [15:0] match_b;
	logic [7:0] pre_a;
	logic [7:0] pre_b;
	logic [31:0] clock_count;
	logic clock_first;
	logic [15:0] clock_div;
	logic access_done;
	logic [1:0] pin_meta;
	logic [1:0] pin_sync;
	logic [1:0] pin_prev;
	logic [1:0] rise;
	logic [1:0] fall;
	logic [1:0] start;
	logic [1:0] load_wr;
	logic wr_cycle;
	logic rd_cycle;
	logic split_mode;
	logic clock_mode;
	logic clock_tick;
	logic clock_match;
	logic [15:0] next_status;
	gtm_pkg::gtm_half_cfg_t cfg_a;
	gtm_pkg::gtm_half_cfg_t cfg_b;
	gtm_pkg::gtm_half_stat_t stat_a;
	gtm_pkg::gtm_half_stat_t stat_b;

	function automatic logic [15:0] merge_half(input logic [15:0] old_v, input logic [15:0] new_v,
		input logic [1:0] be);
		logic [15:0] r;
		r = old_v;
		for (int i = 0; i < 2; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge_half

	function automatic logic hit(input logic [7:0] ofs);
		return wr_cycle && avs_address_i == ofs;
	endfunction : hit

	// one wait state per access: request accepted on the second edge
	assign wr_cycle = avs_write_i && access_done;
	assign rd_cycle = avs_read_i && access_done;
	assign split_mode = timer_configuration == `GTM_CFG_16;
	assign clock_mode = timer_configuration == `GTM_CFG_CLOCK;

	// ****************************************
	// bus handshake
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			access_done <= 1'b0;
		end else begin
			access_done <= (avs_read_i || avs_write_i) && !access_done;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			avs_waitrequest_o <= 1'b1;
		end else begin
			avs_waitrequest_o <= !((avs_read_i || avs_write_i) && !access_done);
		end
	end

	// ****************************************
	// capture pin synchroniser and edges
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			pin_meta <= 2'h0;
			pin_sync <= 2'h0;
			pin_prev <= 2'h0;
		end else begin
			pin_meta <= capture_compare_pin_i;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	assign rise = pin_sync & ~pin_prev;
	assign fall = ~pin_sync & pin_prev;

	// ****************************************
	// configuration and mode
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			timer_configuration <= `GTM_CFG_32;
			timer_a_mode <= 4'h0;
			timer_b_mode <= 4'h0;
			interrupt_mask <= 16'h0000;
			match_a <= 16'hffff;
			match_b <= 16'hffff;
			pre_a <= `GTM_RST_PRE;
			pre_b <= `GTM_RST_PRE;
		end else begin
			if (hit(`GTM_OFS_CFG) && avs_byteenable_i[0]) begin
				timer_configuration <= avs_writedata_i[2:0];
			end
			if (hit(`GTM_OFS_AMODE) && avs_byteenable_i[0]) begin
				timer_a_mode <= avs_writedata_i[3:0];
			end
			if (hit(`GTM_OFS_BMODE) && avs_byteenable_i[0]) begin
				timer_b_mode <= avs_writedata_i[3:0];
			end
			if (hit(`GTM_OFS_IMR)) begin
				interrupt_mask <= merge_half(interrupt_mask, avs_writedata_i[15:0],
					avs_byteenable_i[1:0]);
			end
			if (hit(`GTM_OFS_AMATCH)) begin
				match_a <= merge_half(match_a, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
			end
			if (hit(`GTM_OFS_BMATCH)) begin
				match_b <= merge_half(match_b, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
			end
			if (hit(`GTM_OFS_APR) && avs_byteenable_i[0]) begin
				pre_a <= avs_writedata_i[7:0];
			end
			if (hit(`GTM_OFS_BPR) && avs_byteenable_i[0]) begin
				pre_b <= avs_writedata_i[7:0];
			end
		end
	end

	// ****************************************
	// interval load, 32-bit write fills both halves outside split mode
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			load_a <= `GTM_RST_LOAD;
			load_b <= `GTM_RST_LOAD;
		end else if (hit(`GTM_OFS_AILR)) begin
			load_a <= merge_half(load_a, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
			if (!split_mode) begin
				load_b <= merge_half(load_b, avs_writedata_i[31:16], avs_byteenable_i[3:2]);
			end
		end else if (hit(`GTM_OFS_BILR)) begin
			load_b <= merge_half(load_b, avs_writedata_i[15:0], avs_byteenable_i[1:0]);
		end
	end

	always_comb begin
		load_wr[0] = hit(`GTM_OFS_AILR) && timer_control[`GTM_CTL_EN];
		load_wr[1] = hit(`GTM_OFS_BILR) && timer_control[`GTM_CTL_B + `GTM_CTL_EN];
		start[0] = hit(`GTM_OFS_CTL) && avs_writedata_i[`GTM_CTL_EN]
			&& !timer_control[`GTM_CTL_EN];
		start[1] = hit(`GTM_OFS_CTL) && avs_writedata_i[`GTM_CTL_B + `GTM_CTL_EN]
			&& !timer_control[`GTM_CTL_B + `GTM_CTL_EN];
	end

	// ****************************************
	// control: hardware clears enables on completion
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			timer_control <= 16'h0000;
		end else begin
			if (hit(`GTM_OFS_CTL)) begin
				timer_control <= merge_half(timer_control, avs_writedata_i[15:0],
					avs_byteenable_i[1:0]);
			end
			if (stat_a.done && split_mode) begin
				timer_control[`GTM_CTL_EN] <= 1'b0;
			end
			if (stat_b.done && split_mode) begin
				timer_control[`GTM_CTL_B + `GTM_CTL_EN] <= 1'b0;
			end
		end
	end

	always_comb begin
		cfg_a = '{mode: timer_a_mode[1:0], cmr: timer_a_mode[`GTM_MR_CMR],
			ams: timer_a_mode[`GTM_MR_AMS], evt: timer_control[`GTM_CTL_EVT +: 2],
			stall: timer_control[`GTM_CTL_STALL], inv: timer_control[`GTM_CTL_INV],
			ote: timer_control[`GTM_CTL_OTE], load: load_a, match: match_a, pre: pre_a};
		cfg_b = '{mode: timer_b_mode[1:0], cmr: timer_b_mode[`GTM_MR_CMR],
			ams: timer_b_mode[`GTM_MR_AMS], evt: timer_control[`GTM_CTL_B + `GTM_CTL_EVT +: 2],
			stall: timer_control[`GTM_CTL_B + `GTM_CTL_STALL],
			inv: timer_control[`GTM_CTL_B + `GTM_CTL_INV],
			ote: timer_control[`GTM_CTL_B + `GTM_CTL_OTE], load: load_b, match: match_b,
			pre: pre_b};
	end

	gtm_half u_half_a (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.run_i(split_mode && timer_control[`GTM_CTL_EN]),
		.hold_i(cfg_a.stall && debug_halt_i),
		.start_i(split_mode && start[0]),
		.load_wr_i(split_mode && load_wr[0]),
		.rise_i(rise[0]),
		.fall_i(fall[0]),
		.cfg_i(cfg_a),
		.stat_o(stat_a)
	);

	gtm_half u_half_b (
		.core_clk_i(core_clk_i),
		.reset_n_i(reset_n_i),
		.run_i(split_mode && timer_control[`GTM_CTL_B + `GTM_CTL_EN]),
		.hold_i(cfg_b.stall && debug_halt_i),
		.start_i(split_mode && start[1]),
		.load_wr_i(split_mode && load_wr[1]),
		.rise_i(rise[1]),
		.fall_i(fall[1]),
		.cfg_i(cfg_b),
		.stat_o(stat_b)
	);

	// ****************************************
	// clock mode: 32.768 khz on even pin to 1 hz
	// ****************************************
	assign clock_tick = rise[0] && clock_div == 16'(`GTM_RTC_DIV - 1);
	assign clock_match = clock_tick && clock_count == {match_b, match_a};

	// counter runs under debug halt whatever stall says
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			clock_div <= 16'h0000;
			clock_count <= `GTM_CLOCK_FIRST;
			clock_first <= 1'b1;
		end else if (!clock_mode) begin
			clock_div <= 16'h0000;
			clock_first <= 1'b1;
		end else begin
			if (clock_first) begin
				clock_count <= `GTM_CLOCK_FIRST;
				clock_first <= 1'b0;
			end
			if (timer_control[`GTM_CTL_EN] && rise[0]) begin
				clock_div <= clock_div + 16'h0001;
				if (clock_tick) begin
					clock_div <= 16'h0000;
					clock_count <= clock_match ? 32'h00000000 : clock_count + 32'h00000001;
				end
			end
		end
	end

	// ****************************************
	// status, set wins over clear
	// ****************************************
	always_comb begin
		next_status = raw_interrupt_status;
		if (hit(`GTM_OFS_ICR)) begin
			next_status = next_status & ~merge_half(16'h0000, avs_writedata_i[15:0],
				avs_byteenable_i[1:0]);
		end
		next_status[`GTM_ST_TO] = next_status[`GTM_ST_TO] | stat_a.timeout;
		next_status[`GTM_ST_CM] = next_status[`GTM_ST_CM] | stat_a.count_match;
		next_status[`GTM_ST_CE] = next_status[`GTM_ST_CE] | stat_a.edge_event;
		next_status[`GTM_ST_RTC] = next_status[`GTM_ST_RTC]
			| (clock_match && timer_control[`GTM_CTL_EN]);
		next_status[`GTM_ST_B + `GTM_ST_TO] = next_status[`GTM_ST_B + `GTM_ST_TO] | stat_b.timeout;
		next_status[`GTM_ST_B + `GTM_ST_CM] = next_status[`GTM_ST_B + `GTM_ST_CM]
			| stat_b.count_match;
		next_status[`GTM_ST_B + `GTM_ST_CE] = next_status[`GTM_ST_B + `GTM_ST_CE]
			| stat_b.edge_event;
	end

	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			raw_interrupt_status <= 16'h0000;
			irq_o <= 1'b0;
		end else begin
			raw_interrupt_status <= next_status;
			irq_o <= |(next_status & interrupt_mask);
		end
	end

	// ****************************************
	// pins and triggers
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			capture_compare_pin_o <= 2'h0;
			capture_compare_pin_oe_o <= 2'h0;
			converter_trigger_o <= 2'h0;
		end else begin
			capture_compare_pin_o <= {stat_b.pwm, stat_a.pwm};
			capture_compare_pin_oe_o <= {split_mode && cfg_b.ams && !cfg_b.cmr,
				split_mode && cfg_a.ams && !cfg_a.cmr};
			converter_trigger_o <= {stat_b.trigger, stat_a.trigger};
		end
	end

	// ****************************************
	// read data
	// ****************************************
	always_ff @(posedge core_clk_i) begin
		if (!reset_n_i) begin
			avs_readdata_o <= 32'h00000000;
		end else if ((avs_read_i) && !access_done) begin
			if (avs_address_i == `GTM_OFS_CFG) begin
				avs_readdata_o <= {29'h0, timer_configuration};
			end else if (avs_address_i == `GTM_OFS_AMODE) begin
				avs_readdata_o <= {28'h0, timer_a_mode};
			end else if (avs_address_i == `GTM_OFS_BMODE) begin
				avs_readdata_o <= {28'h0, timer_b_mode};
			end else if (avs_address_i == `GTM_OFS_CTL) begin
				avs_readdata_o <= {16'h0, timer_control};
			end else if (avs_address_i == `GTM_OFS_IMR) begin
				avs_readdata_o <= {16'h0, interrupt_mask};
			end else if (avs_address_i == `GTM_OFS_RIS) begin
				avs_readdata_o <= {16'h0, raw_interrupt_status};
			end else if (avs_address_i == `GTM_OFS_MIS) begin
				avs_readdata_o <= {16'h0, raw_interrupt_status & interrupt_mask};
			end else if (avs_address_i == `GTM_OFS_AILR) begin
				avs_readdata_o <= split_mode ? {16'h0, load_a} : {load_b, load_a};
			end else if (avs_address_i == `GTM_OFS_BILR) begin
				avs_readdata_o <= {16'h0, load_b};
			end else if (avs_address_i == `GTM_OFS_AMATCH) begin
				avs_readdata_o <= {16'h0, match_a};
			end else if (avs_address_i == `GTM_OFS_BMATCH) begin
				avs_readdata_o <= {16'h0, match_b};
			end else if (avs_address_i == `GTM_OFS_APR) begin
				avs_readdata_o <= {24'h0, pre_a};
			end else if (avs_address_i == `GTM_OFS_BPR) begin
				avs_readdata_o <= {24'h0, pre_b};
			end else if (avs_address_i == `GTM_OFS_ACNT) begin
				if (clock_mode) begin
					avs_readdata_o <= clock_count;
				end else if (timer_a_mode[1:0] == `GTM_MODE_CAPTURE && timer_a_mode[`GTM_MR_CMR]) begin
					avs_readdata_o <= {16'h0, stat_a.capture};
				end else begin
					avs_readdata_o <= {16'h0, stat_a.count};
				end
			end else if (avs_address_i == `GTM_OFS_BCNT) begin
				if (timer_b_mode[1:0] == `GTM_MODE_CAPTURE && timer_b_mode[`GTM_MR_CMR]) begin
					avs_readdata_o <= {16'h0, stat_b.capture};
				end else begin
					avs_readdata_o <= {16'h0, stat_b.count};
				end
			end else begin
				avs_readdata_o <= 32'h00000000;
			end
		end
	end

endmodule : gtm_top

// file: verif/gtm_sva.sv
// Purpose: port checks for gtm_top
// Assumes: one clock domain
// Notes: bind at the foot
`timescale 1ns/10ps
module gtm_sva (
	input wire logic core_clk_i,
	input wire logic reset_n_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	input wire logic [1:0] capture_compare_pin_oe_o,
	input wire logic [1:0] converter_trigger_o,
	input wire logic irq_o
);
	logic [2:0] wr_hist;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence req_wait;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	always_ff @(posedge core_clk_i) begin
		wr_hist <= {wr_hist[1:0], avs_write_i & ~avs_waitrequest_o};
	end
	bus_answer_a: assert property (req_wait |=> !avs_waitrequest_o)
		else $error("late answer");
	wait_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("long answer");
	unmapped_zero_a: assert property (req_wait ##0 avs_address_i == 8'hfc |=> avs_readdata_o == 0)
		else $error("unmapped read not zero");
	data_hold_a: assert property (!(avs_read_i && avs_waitrequest_o) |=> $stable(avs_readdata_o))
		else $error("read data moved");
	trig_pulse_a: assert property ((converter_trigger_o & $past(converter_trigger_o)) == 2'h0)
		else $error("trigger longer than a cycle");
	reset_quiet_a: assert property (disable iff (1'b0) !reset_n_i
		|=> irq_o == 0 && converter_trigger_o == 0)
		else $error("outputs busy in reset");
	irq_fall_a: assert property ($fell(irq_o) |-> wr_hist != 0
		|| (avs_write_i && !avs_waitrequest_o))
		else $error("interrupt dropped unasked");
	oe_rise_a: assert property ($rose(capture_compare_pin_oe_o[1]) |-> wr_hist != 0)
		else $error("pwm drive without write");
endmodule : gtm_sva
bind gtm_top gtm_sva u_sva (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
	.capture_compare_pin_oe_o(capture_compare_pin_oe_o),
	.converter_trigger_o(converter_trigger_o), .irq_o(irq_o));

// file: verif/gtm_pin_model.sv
// Purpose: edge source on the capture pins
// Assumes: toggles asked by the bench
// Notes: drives a pin only while its oe is low
`timescale 1ns/10ps
module gtm_pin_model (
	input wire logic clk_i,
	input wire logic [1:0] pwm_i,
	input wire logic [1:0] oe_i,
	output logic [1:0] pin_o
);
	logic [1:0] drv = 2'h0;
	assign pin_o = (oe_i & pwm_i) | (~oe_i & drv);
	task automatic edges(input int i, input int k);
		repeat (k) begin
			@(posedge clk_i);
			drv[i] <= ~drv[i];
			repeat (3) @(posedge clk_i);
		end
	endtask : edges
endmodule : gtm_pin_model

// file: verif/general_purpose_timer_modes_tb_top.sv
// Purpose: self-checking bench for the split timer
// Assumes: register map of gtm_map.svh
// Notes: expectations from written settings
`timescale 1ns/10ps
module general_purpose_timer_modes_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, halt = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, rdata, rdo;
	logic wreq, irq;
	logic [1:0] pin, po, poe, trig;
	int mismatches = 0, comparisons = 0, seed = 32'hea54, n, t, L, M, P;
	int ev[$] = '{0, 1, 3};
	always #50 clk = ~clk;
	gtm_top dut (.core_clk_i(clk), .reset_n_i(rst_n), .avs_address_i(adr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdo),
		.avs_waitrequest_o(wreq), .debug_halt_i(halt), .capture_compare_pin_i(pin),
		.capture_compare_pin_o(po), .capture_compare_pin_oe_o(poe),
		.converter_trigger_o(trig), .irq_o(irq));
	gtm_pin_model pm (.clk_i(clk), .pwm_i(po), .oe_i(poe), .pin_o(pin));
	// ****************
	// bus and checks
	// ****************
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value at %0t: got %h, expected %h", $time, g, e);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (wreq !== 1'b0);
		rdata = rdo;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdata, e);
	endtask : rc
	task automatic wt();
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (trig[0] !== 1'b1);
	endtask : wt
	task automatic print_verdict();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		#(100 * 20000);
		mismatches++;
		print_verdict();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rc(8'h2c, 32'hffff);
		rc(8'h3c, 32'h0);
		rc(8'hfc, 32'h0);
		bus(1'b1, 8'h00, 32'h1);
		rc(8'h48, 32'h1);
		bus(1'b1, 8'h00, 32'h4);
		L = 8 + ($random(seed) & 15);
		P = $random(seed) & 3;
		bus(1'b1, 8'h04, 32'h1);
		bus(1'b1, 8'h28, 32'(L));
		bus(1'b1, 8'h18, 32'h1);
		bus(1'b1, 8'h0c, 32'h21);
		wt();
		rc(8'h1c, 32'h1);
		rc(8'h20, 32'h1);
		chk({31'h0, irq}, 32'h1);
		rc(8'h0c, 32'h20);
		bus(1'b1, 8'h24, 32'h1);
		rc(8'h1c, 32'h0);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 8'h38, 32'(P));
		bus(1'b1, 8'h04, 32'h2);
		bus(1'b1, 8'h0c, 32'h23);
		wt();
		wt();
		chk(32'(n), 32'((L + 1) * (P + 1)));
		halt <= 1'b1;
		repeat (5) @(posedge clk);
		halt <= 1'b0;
		wt();
		chk(32'(n), 32'((L + 1) * (P + 1)));
		foreach (ev[i]) begin
			bus(1'b1, 8'h0c, 32'h0);
			bus(1'b1, 8'h24, 32'hffff);
			bus(1'b1, 8'h08, 32'h3);
			bus(1'b1, 8'h2c, 32'ha);
			bus(1'b1, 8'h34, 32'h6);
			bus(1'b1, 8'h0c, 32'(ev[i] * 1024 + 256));
			pm.edges(1, ev[i] == 3 ? 4 : 8);
			repeat (6) @(posedge clk);
			rc(8'h1c, 32'h200);
			rc(8'h0c, 32'(ev[i] * 1024));
			pm.edges(1, 4);
			rc(8'h4c, 32'ha);
		end
		bus(1'b1, 8'h24, 32'hffff);
		bus(1'b1, 8'h04, 32'h7);
		bus(1'b1, 8'h0c, 32'h1);
		pm.edges(0, 2);
		rc(8'h1c, 32'h4);
		bus(1'b0, 8'h48, 32'h0);
		chk({31'h0, rdata <= 32'(L)}, 32'h1);
		bus(1'b1, 8'h24, 32'hffff);
		M = L / 2;
		bus(1'b1, 8'h2c, 32'(L));
		bus(1'b1, 8'h08, 32'ha);
		bus(1'b1, 8'h34, 32'(M));
		bus(1'b1, 8'h3c, 32'h3);
		for (int v = 0; v < 2; v++) begin
			bus(1'b1, 8'h0c, 32'(v * 16384 + 256));
			repeat (L + 2) @(posedge clk);
			t = 0;
			repeat (L + 1) begin
				@(posedge clk);
				t += po[1];
			end
			chk(32'(t), 32'(v ? M + 1 : L - M));
			chk({30'h0, poe}, 32'h2);
		end
		rc(8'h1c, 32'h0);
		print_verdict();
	end
endmodule : general_purpose_timer_modes_tb_top
